// ### src/addr_latch.sv
// Purpose: latch or fall-through register for one address field
// Assumes: capture strobe is a one-cycle pulse on clk_sys
// Notes: fall through bypasses the stored copy
`timescale 1ns/1ps
module addr_latch #(
	parameter int W = 10
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// control
	input wire logic capture,
	input wire logic fall_through,
	// data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] d_out
);
	logic [W-1:0] held_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			held_q <= '0;
		end else if (capture) begin
			held_q <= d_in;
		end
	end
	assign d_out = fall_through ? d_in : held_q;
endmodule : addr_latch

// ### src/dram_access_mode_bits.sv
// Purpose: mode dependent strobe, address and write enable control
// Assumes: access inputs are synchronous to clk_sys; delay line given as a tap input
// Notes: strobes are active high internally; pins invert outside
`timescale 1ns/1ps
module dram_access_mode_bits
	import dram_mode_pkg::*;
#(
	parameter int ROW_W = 10,
	parameter int COL_W = 10,
	parameter int BANK_W = 2,
	parameter int NCAS = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// programming
	input wire logic mode_load_in,
	input wire logic [PROG_ADDR_W-1:0] prog_addr_in,
	input wire logic prog_latch_mode_in,
	input wire logic prog_access_mode_in,
	input wire logic prog_extend_in,
	// port access
	input wire logic port_a_access_request,
	input wire logic port_b_access_request,
	input wire logic port_b_grant,
	input wire logic address_strobe_in,
	input wire logic latch_strobe_in,
	input wire logic write_access,
	input wire logic [NCAS-1:0] column_extend_input,
	input wire logic [ROW_W-1:0] row_addr_in,
	input wire logic [COL_W-1:0] col_addr_in,
	input wire logic [BANK_W-1:0] bank_addr_in,
	// refresh side
	input wire logic refresh_active,
	input wire logic scrub_refresh,
	input wire logic refresh_pending,
	// delay line tap for column strobe
	input wire logic delay_line_cas,
	// dram side
	output logic row_strobe_out,
	output logic [NCAS-1:0] column_strobe_out,
	output logic write_strobe_pin,
	output logic [ROW_W-1:0] dram_row_addr,
	output logic [COL_W-1:0] dram_col_addr,
	output logic [BANK_W-1:0] dram_bank_addr,
	output logic addr_mux_col,
	// status
	output mode_bits_t mode_bits
);
	// ************************************
	// programming register
	// ************************************
	mode_bits_t mode_q;
	logic mode_load_prev_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_load_prev_q <= 1'b0;
		end else begin
			mode_load_prev_q <= mode_load_in;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_q <= MODE_RESET;
		end else if (mode_load_prev_q && !mode_load_in && !refresh_active) begin
			mode_q.extend_column_strobe_select <= prog_extend_in;
			mode_q.access_mode_select <= prog_access_mode_in;
			mode_q.address_latch_mode_select <= prog_latch_mode_in;
			mode_q.write_column_delay_bit <= prog_addr_in[POS_WR_DELAY];
			mode_q.row_hold_select <= prog_addr_in[POS_ROW_HOLD];
			mode_q.column_setup_select <= prog_addr_in[POS_COL_SETUP];
		end
	end
	assign mode_bits = mode_q;

	// ************************************
	// access start
	// ************************************
	logic access_req;
	logic start_latch_q;
	logic ras_q;
	logic as_prev_q;
	logic ls_prev_q;
	assign access_req = port_a_access_request || (port_b_access_request && port_b_grant);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			as_prev_q <= 1'b0;
			ls_prev_q <= 1'b0;
		end else begin
			as_prev_q <= address_strobe_in;
			ls_prev_q <= latch_strobe_in;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_latch_q <= 1'b0;
		end else if (!access_req) begin
			start_latch_q <= 1'b0;
		end else if (latch_strobe_in && !mode_q.access_mode_select) begin
			start_latch_q <= 1'b1;
		end
	end
	// row strobe on edge after latch
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ras_q <= 1'b0;
		end else if (!access_req) begin
			ras_q <= 1'b0;
		end else if (start_latch_q || (mode_q.access_mode_select && address_strobe_in)) begin
			ras_q <= 1'b1;
		end
	end
	assign row_strobe_out = access_req &&
		(ras_q || (mode_q.access_mode_select && address_strobe_in));

	// ************************************
	// address hold and column setup
	// ************************************
	logic [CNT_W-1:0] hold_cnt_q;
	logic [CNT_W-1:0] setup_cnt_q;
	logic col_ready;
	logic edge_seen_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hold_cnt_q <= CNT_ZERO;
		end else if (!row_strobe_out) begin
			hold_cnt_q <= mode_q.row_hold_select ? ROW_HOLD_SHORT_C : ROW_HOLD_LONG_C;
		end else if (hold_cnt_q != CNT_ZERO) begin
			hold_cnt_q <= hold_cnt_q - CNT_ONE;
		end
	end
	// column address stays off the bus until row hold ends
	assign addr_mux_col = row_strobe_out && (hold_cnt_q == CNT_ZERO);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			setup_cnt_q <= CNT_ZERO;
		end else if (!addr_mux_col) begin
			setup_cnt_q <= mode_q.column_setup_select ? COL_SETUP_SHORT_C : COL_SETUP_LONG_C;
		end else if (setup_cnt_q != CNT_ZERO) begin
			setup_cnt_q <= setup_cnt_q - CNT_ONE;
		end
	end
	// first clock edge after row strobe asserted
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			edge_seen_q <= 1'b0;
		end else begin
			edge_seen_q <= row_strobe_out;
		end
	end

	// ************************************
	// column strobes
	// ************************************
	logic cas_go;
	logic cas_on_q;
	logic [NCAS-1:0] cas_hold_q;
	always_comb begin
		col_ready = addr_mux_col && (setup_cnt_q == CNT_ZERO) && delay_line_cas;
		if (mode_q.write_column_delay_bit && write_access) begin
			cas_go = col_ready && edge_seen_q;
		end else begin
			cas_go = col_ready;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cas_on_q <= 1'b0;
		end else if (!row_strobe_out) begin
			cas_on_q <= 1'b0;
		end else if (cas_go) begin
			cas_on_q <= 1'b1;
		end
	end
	// extended strobes held per extend input
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cas_hold_q <= '0;
		end else if (!mode_q.extend_column_strobe_select || scrub_refresh) begin
			cas_hold_q <= '0;
		end else if (cas_on_q) begin
			cas_hold_q <= column_extend_input;
		end else begin
			cas_hold_q <= cas_hold_q & column_extend_input;
		end
	end
	always_comb begin
		if (scrub_refresh) begin
			column_strobe_out = {NCAS{row_strobe_out && refresh_active}};
		end else if (mode_q.extend_column_strobe_select) begin
			column_strobe_out = ({NCAS{cas_on_q}} | cas_hold_q) & column_extend_input;
		end else begin
			column_strobe_out = {NCAS{cas_on_q && row_strobe_out}};
		end
	end

	// ************************************
	// write pin
	// ************************************
	// write pin function
	assign write_strobe_pin = mode_q.extend_column_strobe_select ? refresh_pending :
		(write_access && row_strobe_out);

	// ************************************
	// address latches
	// ************************************
	logic addr_cap;
	// capture on strobe or granted request
	assign addr_cap = (address_strobe_in && !as_prev_q) || (latch_strobe_in && !ls_prev_q) ||
		(port_b_access_request && port_b_grant);
	addr_latch #(.W(ROW_W)) u_row (
		.clk_sys(clk_sys),
		.rst(rst),
		.capture(addr_cap),
		.fall_through(mode_q.address_latch_mode_select),
		.d_in(row_addr_in),
		.d_out(dram_row_addr)
	);
	addr_latch #(.W(COL_W)) u_col (
		.clk_sys(clk_sys),
		.rst(rst),
		.capture(addr_cap),
		.fall_through(mode_q.address_latch_mode_select),
		.d_in(col_addr_in),
		.d_out(dram_col_addr)
	);
	addr_latch #(.W(BANK_W)) u_bank (
		.clk_sys(clk_sys),
		.rst(rst),
		.capture(addr_cap),
		.fall_through(mode_q.address_latch_mode_select),
		.d_in(bank_addr_in),
		.d_out(dram_bank_addr)
	);
endmodule : dram_access_mode_bits

// ### src/dram_mode_pkg.sv
// Purpose: shared constants and types for the dram access mode block
// Assumes: 40 MHz system clock
// Notes: timing counts are derived from times in ns
package dram_mode_pkg;
	// ************************************
	// clock and timing
	// ************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int ROW_HOLD_LONG_NS = 25;
	localparam int ROW_HOLD_SHORT_NS = 15;
	localparam int COL_SETUP_LONG_NS = 10;
	localparam int COL_SETUP_SHORT_NS = 0;
	// least times round up, never below one cycle
	localparam int ROW_HOLD_LONG_CYC =
		((ROW_HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((ROW_HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int ROW_HOLD_SHORT_CYC =
		((ROW_HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((ROW_HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int COL_SETUP_LONG_CYC =
		((COL_SETUP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((COL_SETUP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int COL_SETUP_SHORT_CYC =
		((COL_SETUP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((COL_SETUP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] ROW_HOLD_LONG_C = CNT_W'(ROW_HOLD_LONG_CYC);
	localparam logic [CNT_W-1:0] ROW_HOLD_SHORT_C = CNT_W'(ROW_HOLD_SHORT_CYC);
	localparam logic [CNT_W-1:0] COL_SETUP_LONG_C = CNT_W'(COL_SETUP_LONG_CYC);
	localparam logic [CNT_W-1:0] COL_SETUP_SHORT_C = CNT_W'(COL_SETUP_SHORT_CYC);
	// ************************************
	// programming word layout
	// ************************************
	localparam int POS_COL_SETUP = 7;
	localparam int POS_ROW_HOLD = 8;
	localparam int POS_WR_DELAY = 9;
	localparam int PROG_ADDR_W = 10;
	typedef struct packed {
		logic extend_column_strobe_select;
		logic access_mode_select;
		logic address_latch_mode_select;
		logic write_column_delay_bit;
		logic row_hold_select;
		logic column_setup_select;
	} mode_bits_t;
	localparam mode_bits_t MODE_RESET = '0;
endpackage : dram_mode_pkg

// ### verification/bus_req_model.sv
// Purpose: processor side model issuing port a accesses
// Assumes: go is seen on a rising clk_sys edge
// Notes: fixed length keeps bench timing simple
`timescale 1ns/1ps
module bus_req_model (
	// command
	input wire logic clk_sys,
	input wire logic go,
	input wire logic mode1,
	// to controller
	output logic req,
	output logic astb,
	output logic lstb,
	output logic [3:0] ext,
	output logic dly
);
	initial begin
		{req, astb, lstb, ext, dly} = '0;
	end
	always @(posedge clk_sys) begin
		if (go) begin
			#2;
			req = 1'h1;
			ext = 4'hf;
			astb = mode1;
			lstb = !mode1;
			@(posedge clk_sys);
			#2;
			astb = 1'h0;
			lstb = 1'h0;
			@(posedge clk_sys);
			#2;
			dly = 1'h1;
			repeat (7) @(posedge clk_sys);
			#2;
			req = 1'h0;
			dly = 1'h0;
			@(posedge clk_sys);
			#2;
			ext = 4'h0;
		end
	end
endmodule : bus_req_model

// ### verification/dram_access_mode_bits_props.sv
// Purpose: port assertions for dram_access_mode_bits
// Assumes: one clock, sync active high reset
// Notes: port b is not watched here
`timescale 1ns/1ps
module dram_access_mode_bits_props
	import dram_mode_pkg::*;
#(
	parameter int ROW_W = 10,
	parameter int NCAS = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// inputs
	input wire logic mode_load_in,
	input wire logic [PROG_ADDR_W-1:0] prog_addr_in,
	input wire logic prog_latch_mode_in,
	input wire logic prog_access_mode_in,
	input wire logic prog_extend_in,
	input wire logic port_a_access_request,
	input wire logic address_strobe_in,
	input wire logic latch_strobe_in,
	input wire logic write_access,
	input wire logic [NCAS-1:0] column_extend_input,
	input wire logic [ROW_W-1:0] row_addr_in,
	input wire logic refresh_active,
	input wire logic scrub_refresh,
	input wire logic refresh_pending,
	// outputs
	input wire logic row_strobe_out,
	input wire logic [NCAS-1:0] column_strobe_out,
	input wire logic write_strobe_pin,
	input wire logic [ROW_W-1:0] dram_row_addr,
	input wire logic addr_mux_col,
	input wire mode_bits_t mode_bits
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic ext;
	logic m1;
	logic req;
	logic [5:0] prog_w;
	assign ext = mode_bits.extend_column_strobe_select;
	assign m1 = mode_bits.access_mode_select;
	assign req = port_a_access_request;
	assign prog_w = {prog_extend_in, prog_access_mode_in, prog_latch_mode_in,
		prog_addr_in[POS_WR_DELAY:POS_COL_SETUP]};
	// ************
	// assertions
	// ************
	sequence s_latch; !m1 && latch_strobe_in && req ##1 req; endsequence
	property p_latch; s_latch |=> row_strobe_out || !req; endproperty
	a_latch: assert property (p_latch) else $error("late row strobe");
	property p_ads; m1 && address_strobe_in && req |-> row_strobe_out; endproperty
	a_ads: assert property (p_ads) else $error("row strobe waited");
	property p_drop; $fell(req) && !ext && !refresh_active
		|-> !row_strobe_out && column_strobe_out == '0; endproperty
	a_drop: assert property (p_drop) else $error("strobes stayed");
	property p_ext; ext && !refresh_active |-> (column_strobe_out & ~column_extend_input) == '0;
	endproperty
	a_ext: assert property (p_ext) else $error("column outlived extend");
	property p_scrub; refresh_active && scrub_refresh
		|-> column_strobe_out == {NCAS{row_strobe_out}}; endproperty
	a_scrub: assert property (p_scrub) else $error("scrub column wrong");
	property p_we; !ext |-> write_strobe_pin == (write_access && row_strobe_out); endproperty
	a_we: assert property (p_we) else $error("write pin wrong");
	property p_refresh_request_out; ext |-> write_strobe_pin == refresh_pending; endproperty
	a_refresh_request_out: assert property (p_refresh_request_out) else $error("refresh pin wrong");
	property p_pass; mode_bits.address_latch_mode_select |-> dram_row_addr == row_addr_in;
	endproperty
	a_pass: assert property (p_pass) else $error("latch not transparent");
	property p_load; $fell(mode_load_in) && !refresh_active |=> mode_bits == $past(prog_w);
	endproperty
	a_load: assert property (p_load) else $error("mode bits not loaded");
	// column address may only appear after a clocked row hold
	property p_hold; $rose(addr_mux_col) |-> $past(row_strobe_out); endproperty
	a_hold: assert property (p_hold) else $error("row hold skipped");
	property p_setup; $rose(|column_strobe_out) && !refresh_active |-> $past(addr_mux_col);
	endproperty
	a_setup: assert property (p_setup) else $error("column setup skipped");
	property p_wrdly; $rose(|column_strobe_out) && write_access && !refresh_active
		&& mode_bits.write_column_delay_bit |-> $past(row_strobe_out); endproperty
	a_wrdly: assert property (p_wrdly) else $error("write column too early");
endmodule : dram_access_mode_bits_props
bind dram_access_mode_bits dram_access_mode_bits_props #(.ROW_W(ROW_W), .NCAS(NCAS)) props_u (
	.clk_sys, .rst, .mode_load_in, .prog_addr_in, .prog_latch_mode_in, .prog_access_mode_in,
	.prog_extend_in, .port_a_access_request, .address_strobe_in, .latch_strobe_in,
	.write_access, .column_extend_input, .row_addr_in, .refresh_active, .scrub_refresh,
	.refresh_pending, .row_strobe_out, .column_strobe_out, .write_strobe_pin, .dram_row_addr,
	.addr_mux_col, .mode_bits
);

// ### verification/dram_access_mode_bits_tb.sv
// Purpose: self-checking bench for dram_access_mode_bits
// Assumes: inputs move 2 ns after the rising edge
// Notes: port b request, only when granted, drives address capture and the access request; arbitration lives elsewhere
`timescale 1ns/1ps
module dram_access_mode_bits_tb
	import dram_mode_pkg::*;
;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic mload = 1'h0, wr = 1'h0, go = 1'h0, ra = 1'h0, sc = 1'h0, rp = 1'h0;
	logic pbr = 1'h0, pbg = 1'h0;
	logic req, astb, lstb, dly, rso, wsp;
	logic [9:0] pa = '0, ra_in = '0, old = '0, dra;
	logic [3:0] ext, cso;
	logic [2:0] pb = '0;
	mode_bits_t mb, em = MODE_RESET;
	int error_cnt = 0, cmp_count = 0, seed = 34092, i;
	logic [31:0] r = '0;
	always #12.5 clk_sys = ~clk_sys;
	dram_access_mode_bits dut_u (.clk_sys, .rst, .mode_load_in(mload), .prog_addr_in(pa),
		.prog_latch_mode_in(pb[0]), .prog_access_mode_in(pb[1]), .prog_extend_in(pb[2]),
		.port_a_access_request(req), .port_b_access_request(pbr), .port_b_grant(pbg),
		.address_strobe_in(astb), .latch_strobe_in(lstb), .write_access(wr),
		.column_extend_input(ext), .row_addr_in(ra_in), .col_addr_in(r[19:10]),
		.bank_addr_in(r[21:20]), .refresh_active(ra), .scrub_refresh(sc), .refresh_pending(rp),
		.delay_line_cas(dly), .row_strobe_out(rso), .column_strobe_out(cso),
		.write_strobe_pin(wsp), .dram_row_addr(dra), .dram_col_addr(), .dram_bank_addr(),
		.addr_mux_col(), .mode_bits(mb));
	bus_req_model bus_u (.clk_sys, .go, .mode1(em.access_mode_select), .req, .astb, .lstb,
		.ext, .dly);
	task automatic tick;
		@(posedge clk_sys);
		#2;
	endtask : tick
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic report_and_stop;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	function automatic logic [4:0] after_req(input mode_bits_t m);
		return {1'h0, m.extend_column_strobe_select ? 4'hf : 4'h0};
	endfunction : after_req
	function automatic logic pin_exp(input mode_bits_t m);
		return m.extend_column_strobe_select ? rp : wr;
	endfunction : pin_exp
	// busy load during refresh must be ignored
	task automatic load(input mode_bits_t v, input logic busy);
		tick;
		r = $random(seed);
		mload = 1'h1;
		ra = busy;
		sc = r[0];
		pa = {v[2:0], r[6:0]};
		pb = v[5:3];
		tick;
		mload = 1'h0;
		tick;
		// scrub flag blanks the column strobes even outside a refresh
		ra = 1'h0;
		sc = 1'h0;
		if (!busy) em = v;
		// granted port b request captures the address
		pbr = 1'h1;
		pbg = r[7];
		ra_in = r[17:8];
		tick;
		pbr = 1'h0;
		pbg = 1'h0;
		if (r[7]) old = ra_in;
		chk(mb, em);
		chk(dra, em.address_latch_mode_select ? ra_in : old);
	endtask : load
	task automatic access;
		r = $random(seed);
		ra_in = r[9:0];
		old = r[9:0];
		wr = r[22];
		rp = r[23];
		go = 1'h1;
		tick;
		go = 1'h0;
		// partner moves 2 ns after the edge as well, so look mid-cycle
		@(negedge clk_sys);
		chk(rso, em.access_mode_select);
		tick;
		r = $random(seed);
		ra_in = r[9:0];
		@(negedge clk_sys);
		chk(rso, em.access_mode_select);
		tick;
		@(negedge clk_sys);
		chk(rso, 1'h1);
		chk(dra, em.address_latch_mode_select ? r[9:0] : old);
		chk(wsp, pin_exp(em));
		repeat (7) tick;
		@(negedge clk_sys);
		chk({rso, cso}, after_req(em));
		tick;
		@(negedge clk_sys);
		chk(cso, 4'h0);
		tick;
	endtask : access
	initial begin
		repeat (20) @(posedge clk_sys);
		#2;
		rst = 1'h0;
		chk(mb, MODE_RESET);
		for (i = 0; i < 40; i++) begin
			r = $random(seed);
			load(i == 0 ? 6'h3f : i == 1 ? 6'h00 : r[5:0], i % 5 == 4);
			access;
		end
		report_and_stop;
	end
	initial begin
		#100000;
		error_cnt++;
		report_and_stop;
	end
endmodule : dram_access_mode_bits_tb
